/* File: src/mcr_router.sv */
`default_nettype none
module mcr_router (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic [7:0]   rx_byte_i,
  input  wire logic         rx_valid_i,
  output logic [7:0]        out_byte_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic              thru_mode_o,
  input  wire logic         cfg_wr_i,
  input  wire mcr_pkg::mcr_cfg_s cfg_i,
  input  wire mcr_pkg::mcr_cfg_s nv_cfg_i,
  output mcr_pkg::mcr_cfg_s cfg_o,
  input  wire logic         link_active_i,
  input  wire logic         seq_playing_i,
  input  wire logic         aux_create_main_i,
  input  wire logic         aux_delete_main_i,
  output logic [7:0]        inst_exists_o,
  input  wire logic         src_valid_i,
  input  wire mcr_pkg::mcr_src_s src_i,
  output logic              src_ready_o,
  output logic              eng_valid_o,
  output mcr_pkg::mcr_eng_s eng_o,
  output logic              loc_valid_o,
  output mcr_pkg::mcr_src_s loc_o,
  input  wire logic         metro_tick_i,
  input  wire logic         seq_start_i,
  input  wire logic         seq_stop_i,
  output logic              clk_tick_o,
  output logic              seq_start_o,
  output logic              seq_stop_o
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_D1   = 2'b01,
    TX_D2   = 2'b11
  } mcr_tx_e;

  typedef struct packed {
    mcr_pkg::mcr_cfg_s cfg;
    logic              loaded;
    logic              main_ex;
    logic [7:3]        xex;
    logic [7:3]        prog;
    mcr_tx_e           st;
    mcr_pkg::mcr_msg_s tm;
    logic              pclk;
    logic              pstart;
    logic              pstop;
    logic [7:0]        ob;
    logic              ov;
    logic              ev;
    mcr_pkg::mcr_eng_s e;
    logic              lv;
    mcr_pkg::mcr_src_s l;
    logic              ct;
    logic              ss;
    logic              sp;
  } mcr_rtr_s;

  mcr_rtr_s          s;
  mcr_rtr_s          next_s;
  logic              pm_valid;
  mcr_pkg::mcr_msg_s pm;
  logic              prt_valid;
  logic [7:0]        prt;
  logic [7:0]        ex;
  logic [3:0]        off;
  logic              in_sel;
  logic              is_note;
  logic              is_pc;
  logic              is_par;
  logic              is_mode;
  logic              ch_ok;
  logic              thru;
  logic              out_free;
  logic              rt_pend;
  logic              s_blk;
  logic              s_tx;
  logic              s_take;
  logic [3:0]        s_ch;

  mcr_parser u_parser (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .rx_byte_i   (rx_byte_i),
    .rx_valid_i  (rx_valid_i),
    .msg_valid_o (pm_valid),
    .msg_o       (pm),
    .rt_valid_o  (prt_valid),
    .rt_byte_o   (prt)
  );

  // Main, linked, sequencer, and the remotely created extra instruments
  assign ex = {s.xex, seq_playing_i, link_active_i, s.main_ex};
  // Thru unless something must be generated, or a remote party forced Out
  assign thru = (s.cfg.tx_en == 3'h0) && !s.cfg.clk_out_en && !s.cfg.force_out;
  assign out_free = !s.ov || out_ready_i;
  assign rt_pend = s.pclk || s.pstart || s.pstop;

  always_comb begin
    off = pm.status[3:0] - s.cfg.base_ch;
    is_note = (pm.status[7:4] == mcr_pkg::HI_NOTE_ON) || (pm.status[7:4] == mcr_pkg::HI_NOTE_OFF);
    is_pc = pm.status[7:4] == mcr_pkg::HI_PROG;
    is_par = (pm.status[7:4] == mcr_pkg::HI_CTRL) && pm.d1 >= mcr_pkg::CC_PAR_LO
             && pm.d1 <= mcr_pkg::CC_PAR_HI;
    is_mode = (pm.status[7:4] == mcr_pkg::HI_CTRL) && pm.d1 >= mcr_pkg::CC_OMNI_OFF;
    in_sel = (off < mcr_pkg::N_SRC) && s.cfg.rx_en[off[1:0]];
    if (s.cfg.omni) begin
      ch_ok = ex[0];
    end else if (off < mcr_pkg::N_SRC) begin
      ch_ok = in_sel && ex[off[2:0]];
    end else if (off < mcr_pkg::N_INST) begin
      ch_ok = ex[off[2:0]] && (!is_note || s.prog[off[2:0]]);
    end else begin
      ch_ok = 1'b0;
    end
    s_ch = s.cfg.omni ? s.cfg.base_ch : s.cfg.base_ch + {2'h0, src_i.src};
    s_blk = ((src_i.msg.status[7:4] == mcr_pkg::HI_PROG) || ((src_i.msg.status[7:4] == mcr_pkg::HI_CTRL)
            && src_i.msg.d1 >= mcr_pkg::CC_PAR_LO && src_i.msg.d1 <= mcr_pkg::CC_PAR_HI))
            && !s.cfg.panel_filter;
    // System messages from sources are never transmitted, so song position and select leave only as Thru echoes
    s_tx = s.cfg.tx_en[src_i.src] && !s_blk && src_i.msg.status[7:4] != 4'hf && !thru;
    src_ready_o = !s_tx || (s.st == TX_IDLE && out_free && !rt_pend);
    s_take = src_valid_i && src_ready_o;
  end

  always_comb begin
    next_s = s;
    next_s.ev = 1'b0;
    next_s.lv = 1'b0;
    next_s.ct = 1'b0;
    next_s.ss = 1'b0;
    next_s.sp = 1'b0;
    if (out_ready_i) begin
      next_s.ov = 1'b0;
    end
    if (!s.loaded) begin
      next_s.loaded = 1'b1;
      next_s.cfg = nv_cfg_i;
      next_s.cfg.local_en = 3'h7;
    end else if (cfg_wr_i) begin
      next_s.cfg = cfg_i;
    end
    if (aux_create_main_i) begin
      next_s.main_ex = 1'b1;
    end
    if (aux_delete_main_i) begin
      next_s.main_ex = 1'b0;
    end
    if (pm_valid) begin
      if (pm.status == mcr_pkg::ST_SYSEX) begin
        if (pm.d1 == mcr_pkg::SX_FORCE_OUT) begin
          next_s.cfg.force_out = 1'b1;
        end else if (pm.d1 == mcr_pkg::SX_CREATE || pm.d1 == mcr_pkg::SX_DELETE) begin
          if (pm.d2 == 8'h00) begin
            next_s.main_ex = (pm.d1 == mcr_pkg::SX_CREATE);
          end else if (pm.d2 >= 8'h03 && pm.d2 < 8'h08) begin
            next_s.xex[pm.d2[2:0]] = (pm.d1 == mcr_pkg::SX_CREATE);
            next_s.prog[pm.d2[2:0]] = 1'b0;
          end
        end
      end else if (pm.status[7:4] != 4'hf) begin
        if (is_mode && (s.cfg.omni || in_sel)) begin
          unique case (pm.d1)
            mcr_pkg::CC_OMNI_OFF: next_s.cfg.omni = 1'b0;
            mcr_pkg::CC_OMNI_ON:  next_s.cfg.omni = 1'b1;
            mcr_pkg::CC_MONO:     next_s.cfg.mono = 1'b1;
            default:              next_s.cfg.mono = 1'b0;
          endcase
        end else if (ch_ok && !((is_pc || is_par) && !s.cfg.panel_filter) && !is_mode) begin
          next_s.ev = 1'b1;
          next_s.e.inst = s.cfg.omni ? 3'h0 : off[2:0];
          // The engine picks the most recent voice of the instrument in Mono
          next_s.e.mono = s.cfg.mono;
          next_s.e.msg = pm;
          if (is_pc && !s.cfg.omni && off >= mcr_pkg::N_SRC) begin
            next_s.prog[off[2:0]] = (pm.d1 != 8'h00);
          end
        end
      end
    end
    if (prt_valid) begin
      unique case (prt)
        mcr_pkg::ST_CLOCK: next_s.ct = s.cfg.clk_in_en;
        mcr_pkg::ST_START: next_s.ss = s.cfg.clk_in_en;
        mcr_pkg::ST_STOP:  next_s.sp = s.cfg.clk_in_en;
        mcr_pkg::ST_RESET: begin
          next_s.cfg.tx_en = 3'h0;
          next_s.cfg.local_en = 3'h7;
          next_s.cfg.omni = 1'b1;
          next_s.cfg.mono = 1'b0;
        end
        default: ;
      endcase
    end
    if (metro_tick_i && s.cfg.clk_out_en) begin
      next_s.pclk = 1'b1;
    end
    if (seq_start_i && s.cfg.clk_out_en) begin
      next_s.pstart = 1'b1;
    end
    if (seq_stop_i && s.cfg.clk_out_en) begin
      next_s.pstop = 1'b1;
    end
    if (s_take && s.cfg.local_en[src_i.src]) begin
      next_s.lv = 1'b1;
      next_s.l = src_i;
    end
    if (thru) begin
      // Echo path has no back-pressure: the far end paces the wire
      next_s.st = TX_IDLE;
      next_s.pclk = 1'b0;
      next_s.pstart = 1'b0;
      next_s.pstop = 1'b0;
      if (rx_valid_i) begin
        next_s.ov = 1'b1;
        next_s.ob = rx_byte_i;
      end
    end else if (out_free) begin
      // Real-time bytes may cut between the bytes of a message
      if (s.pclk) begin
        next_s.ov = 1'b1;
        next_s.ob = mcr_pkg::ST_CLOCK;
        // A request landing in the sending cycle must not be wiped
        next_s.pclk = metro_tick_i && s.cfg.clk_out_en;
      end else if (s.pstart) begin
        next_s.ov = 1'b1;
        next_s.ob = mcr_pkg::ST_START;
        next_s.pstart = seq_start_i && s.cfg.clk_out_en;
      end else if (s.pstop) begin
        next_s.ov = 1'b1;
        next_s.ob = mcr_pkg::ST_STOP;
        next_s.pstop = seq_stop_i && s.cfg.clk_out_en;
      end else begin
        unique case (s.st)
          TX_IDLE: begin
            if (s_take && s_tx) begin
              next_s.ov = 1'b1;
              next_s.ob = {src_i.msg.status[7:4], s_ch};
              next_s.tm = src_i.msg;
              next_s.st = (mcr_pkg::mcr_data_len(src_i.msg.status) == 2'h0) ? TX_IDLE : TX_D1;
            end
          end
          TX_D1: begin
            next_s.ov = 1'b1;
            next_s.ob = s.tm.d1;
            next_s.st = (mcr_pkg::mcr_data_len(s.tm.status) == 2'h2) ? TX_D2 : TX_IDLE;
          end
          TX_D2: begin
            next_s.ov = 1'b1;
            next_s.ob = s.tm.d2;
            next_s.st = TX_IDLE;
          end
          default: next_s.st = TX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '{cfg: mcr_pkg::CFG_RST, main_ex: 1'b1, st: TX_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign out_byte_o    = s.ob;
  assign out_valid_o   = s.ov;
  assign thru_mode_o   = thru;
  assign cfg_o         = s.cfg;
  assign inst_exists_o = ex;
  assign eng_valid_o   = s.ev;
  assign eng_o         = s.e;
  assign loc_valid_o   = s.lv;
  assign loc_o         = s.l;
  assign clk_tick_o    = s.ct;
  assign seq_start_o   = s.ss;
  assign seq_stop_o    = s.sp;
endmodule : mcr_router
`default_nettype wire

/* File: src/mcr_pkg.sv */
// Summary of operation
// - Accept received messages for a source channel only while its receive enable is set.
// - Transmit main, linked or sequencer output only while that source's transmit enable is set.
// - A source reaches the sound engine only while its internal routing enable is set.
// - Panel filter off drops program and parameter changes both ways; on passes them.
// - Main instrument exists unless deleted by MIDI or auxiliary request.
// - Linked instrument exists exactly while a link is established.
// - Sequencer instrument exists exactly while sequence playback runs.
// - Instruments 3 to 7 exist once created remotely; notes need a non-zero program.
// - Poly, Mono, Poly/Omni, Mono/Omni modes, set from panel or MIDI, kept across power loss.
// - In Omni, messages on all 16 channels go to the main instrument.
// - In Omni, all three sources transmit on the base channel.
// - In Mono, received Note On goes to the instrument's most recently used voice.
// - Mono applies to every input channel and leaves transmission alone.
// - One global mode; Mode Change taken on enabled inputs, or any channel in Omni.
// - Parameter changes use undefined Control Change numbers, passed only with panel filter on.
// - Metronome follows received timing clocks or generates them, beside the pulse sync.
// - Start and Stop sent only with clock output on, obeyed only with clock input on.
// - Continue, Song Position and Song Select are ignored and never sent; the code still echoes received ones in Thru mode.
// - Output is Thru when no transmit enable and no clock output; otherwise Out.
// - A System Exclusive command forces the output connector into Out mode.
// - Settings survive power loss; internal routing enables are all set at power-up.
// - Received Reset clears transmit enables, sets routing enables, selects Poly/Omni.
// - Main, linked, sequencer enables map to base, base plus one, base plus two.
`default_nettype none
package mcr_pkg;
  localparam logic [3:0] HI_NOTE_OFF = 4'h8;
  localparam logic [3:0] HI_NOTE_ON  = 4'h9;
  localparam logic [3:0] HI_CTRL     = 4'hb;
  localparam logic [3:0] HI_PROG     = 4'hc;
  localparam logic [7:0] ST_SYSEX    = 8'hf0;
  localparam logic [7:0] ST_EOX      = 8'hf7;
  localparam logic [7:0] ST_RT_LO    = 8'hf8;
  localparam logic [7:0] ST_CLOCK    = 8'hf8;
  localparam logic [7:0] ST_START    = 8'hfa;
  localparam logic [7:0] ST_STOP     = 8'hfc;
  localparam logic [7:0] ST_RESET    = 8'hff;
  localparam logic [7:0] CC_OMNI_OFF = 8'h7c;
  localparam logic [7:0] CC_OMNI_ON  = 8'h7d;
  localparam logic [7:0] CC_MONO     = 8'h7e;
  localparam logic [7:0] CC_POLY     = 8'h7f;
  // Undefined controller numbers carrying instrument parameters
  localparam logic [7:0] CC_PAR_LO   = 8'h14;
  localparam logic [7:0] CC_PAR_HI   = 8'h1f;
  // Arbitrary neutral value
  localparam logic [7:0] SX_ID       = 8'h7d;
  localparam logic [7:0] SX_FORCE_OUT = 8'h01;
  localparam logic [7:0] SX_CREATE   = 8'h02;
  localparam logic [7:0] SX_DELETE   = 8'h03;
  localparam logic [1:0] SX_LEN      = 2'h3;
  localparam logic [3:0] N_SRC       = 4'h3;
  localparam logic [3:0] N_INST      = 4'h8;

  typedef struct packed {
    logic [2:0] rx_en;
    logic [2:0] tx_en;
    logic [2:0] local_en;
    logic       panel_filter;
    logic       omni;
    logic       mono;
    logic       clk_out_en;
    logic       clk_in_en;
    logic       force_out;
    logic [3:0] base_ch;
  } mcr_cfg_s;

  localparam mcr_cfg_s CFG_RST = '{rx_en: 3'h7, tx_en: 3'h0, local_en: 3'h7,
    panel_filter: 1'b0, omni: 1'b1, mono: 1'b0, clk_out_en: 1'b0,
    clk_in_en: 1'b0, force_out: 1'b0, base_ch: 4'h0};

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] d1;
    logic [7:0] d2;
  } mcr_msg_s;

  typedef struct packed {
    logic [1:0] src;
    mcr_msg_s   msg;
  } mcr_src_s;

  typedef struct packed {
    logic [2:0] inst;
    logic       mono;
    mcr_msg_s   msg;
  } mcr_eng_s;

  function automatic logic [1:0] mcr_data_len(input logic [7:0] st);
    logic [1:0] n;
    n = 2'h0;
    unique case (st[7:4])
      4'hc, 4'hd: n = 2'h1;
      4'hf:       n = (st == 8'hf2) ? 2'h2 : ((st == 8'hf1 || st == 8'hf3) ? 2'h1 : 2'h0);
      default:    n = st[7] ? 2'h2 : 2'h0;
    endcase
    return n;
  endfunction : mcr_data_len
endpackage : mcr_pkg
`default_nettype wire

/* File: src/mcr_parser.sv */
`default_nettype none
module mcr_parser (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic [7:0]   rx_byte_i,
  input  wire logic         rx_valid_i,
  output logic              msg_valid_o,
  output mcr_pkg::mcr_msg_s msg_o,
  output logic              rt_valid_o,
  output logic [7:0]        rt_byte_o
);
  typedef struct packed {
    logic [7:0]        run;
    logic [7:0]        d1;
    logic              cnt;
    logic              in_sx;
    logic [1:0]        sx_idx;
    logic [7:0]        sx_id;
    logic [7:0]        sx_cmd;
    logic [7:0]        sx_arg;
    logic              mv;
    mcr_pkg::mcr_msg_s m;
    logic              rv;
    logic [7:0]        rb;
  } mcr_prs_s;

  mcr_prs_s s;
  mcr_prs_s next_s;
  logic [7:0] b;
  logic [1:0] len;

  assign b = rx_byte_i;

  always_comb begin
    next_s = s;
    next_s.mv = 1'b0;
    next_s.rv = 1'b0;
    len = mcr_pkg::mcr_data_len(s.run);
    if (rx_valid_i) begin
      if (b >= mcr_pkg::ST_RT_LO) begin
        // Real-time bytes may land inside any message and leave it intact
        next_s.rv = 1'b1;
        next_s.rb = b;
      end else if (b[7]) begin
        next_s.cnt = 1'b0;
        next_s.in_sx = (b == mcr_pkg::ST_SYSEX);
        next_s.sx_idx = 2'h0;
        next_s.run = b;
        if (b == mcr_pkg::ST_EOX || b == mcr_pkg::ST_SYSEX) begin
          next_s.run = 8'h00;
          if (b == mcr_pkg::ST_EOX && s.in_sx && s.sx_idx == mcr_pkg::SX_LEN && s.sx_id == mcr_pkg::SX_ID) begin
            next_s.mv = 1'b1;
            next_s.m = '{status: mcr_pkg::ST_SYSEX, d1: s.sx_cmd, d2: s.sx_arg};
          end
        end else if (mcr_pkg::mcr_data_len(b) == 2'h0) begin
          next_s.run = 8'h00;
          next_s.mv = 1'b1;
          next_s.m = '{status: b, d1: 8'h00, d2: 8'h00};
        end
      end else if (s.in_sx) begin
        unique case (s.sx_idx)
          2'h0: next_s.sx_id = b;
          2'h1: next_s.sx_cmd = b;
          2'h2: next_s.sx_arg = b;
          2'h3: next_s.sx_id = 8'h00;
        endcase
        if (s.sx_idx != mcr_pkg::SX_LEN) begin
          next_s.sx_idx = s.sx_idx + 2'h1;
        end
      end else if (s.run != 8'h00) begin
        if (!s.cnt && len == 2'h2) begin
          next_s.d1 = b;
          next_s.cnt = 1'b1;
        end else begin
          next_s.mv = 1'b1;
          next_s.cnt = 1'b0;
          next_s.m = s.cnt ? '{status: s.run, d1: s.d1, d2: b} : '{status: s.run, d1: b, d2: 8'h00};
          // System common messages carry no running status
          if (s.run[7:4] == 4'hf) begin
            next_s.run = 8'h00;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign msg_valid_o = s.mv;
  assign msg_o       = s.m;
  assign rt_valid_o  = s.rv;
  assign rt_byte_o   = s.rb;
endmodule : mcr_parser
`default_nettype wire

/* File: tb/mcr_router_checker.sv */
`default_nettype none
module mcr_router_checker (
  input wire logic              mclk_i,
  input wire logic              nrst_i,
  input wire logic [7:0]        rx_byte_i,
  input wire logic              rx_valid_i,
  input wire logic [7:0]        out_byte_o,
  input wire logic              out_valid_o,
  input wire logic              thru_mode_o,
  input wire mcr_pkg::mcr_cfg_s cfg_o,
  input wire logic              link_active_i,
  input wire logic              seq_playing_i,
  input wire logic              aux_delete_main_i,
  input wire logic [7:0]        inst_exists_o,
  input wire logic              src_valid_i,
  input wire mcr_pkg::mcr_src_s src_i,
  input wire logic              src_ready_o,
  input wire logic              eng_valid_o,
  input wire mcr_pkg::mcr_eng_s eng_o,
  input wire logic              loc_valid_o,
  input wire logic              seq_start_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_take;
    src_valid_i && src_ready_o && cfg_o.tx_en[src_i.src] && !thru_mode_o
      && src_i.msg.status[7:4] == mcr_pkg::HI_NOTE_ON;
  endsequence
  sequence s_sent;
    out_valid_o && out_byte_o[7:4] == mcr_pkg::HI_NOTE_ON;
  endsequence
  property p_tx_chan;
    s_take |=> s_sent ##0 out_byte_o[3:0] == ($past(cfg_o.omni) ? $past(cfg_o.base_ch)
      : $past(cfg_o.base_ch) + {2'h0, $past(src_i.src)});
  endproperty
  property p_tx_gate;
    src_valid_i && src_ready_o && !cfg_o.tx_en[src_i.src] && !out_valid_o && !rx_valid_i |=> !out_valid_o;
  endproperty
  property p_thru;
    thru_mode_o == (cfg_o.tx_en == 3'h0 && !cfg_o.clk_out_en && !cfg_o.force_out);
  endproperty
  property p_loc;
    src_valid_i && src_ready_o |=> loc_valid_o == $past(cfg_o.local_en[src_i.src]);
  endproperty
  property p_reset;
    rx_valid_i && rx_byte_i == mcr_pkg::ST_RESET |-> ##2
      (cfg_o.tx_en == 3'h0 && cfg_o.local_en == 3'h7 && cfg_o.omni && !cfg_o.mono);
  endproperty
  property p_omni;
    eng_valid_o && $past(cfg_o.omni) |-> eng_o.inst == 3'h0;
  endproperty
  property p_mono;
    eng_valid_o |-> eng_o.mono == $past(cfg_o.mono);
  endproperty
  property p_panel;
    eng_valid_o && !$past(cfg_o.panel_filter) |-> eng_o.msg.status[7:4] != mcr_pkg::HI_PROG;
  endproperty
  property p_start_rx;
    rx_valid_i && rx_byte_i == mcr_pkg::ST_START |-> ##2 seq_start_o == $past(cfg_o.clk_in_en);
  endproperty
  property p_no_song;
    out_valid_o && !thru_mode_o |-> !(out_byte_o inside {8'hf2, 8'hf3, 8'hfb});
  endproperty
  property p_inst;
    inst_exists_o[2:1] == {seq_playing_i, link_active_i};
  endproperty
  property p_del;
    aux_delete_main_i |=> !inst_exists_o[0];
  endproperty
  a_tx_chan: assert property (p_tx_chan) else $error("wrong transmit channel");
  a_tx_gate: assert property (p_tx_gate) else $error("disabled source sent");
  a_thru: assert property (p_thru) else $error("thru mode mismatch");
  a_loc: assert property (p_loc) else $error("local routing mismatch");
  a_reset: assert property (p_reset) else $error("reset byte not applied");
  a_omni: assert property (p_omni) else $error("omni event not on main");
  a_mono: assert property (p_mono) else $error("mono flag mismatch");
  a_panel: assert property (p_panel) else $error("program change passed filter");
  a_start_rx: assert property (p_start_rx) else $error("start handling wrong");
  a_no_song: assert property (p_no_song) else $error("song message sent");
  a_inst: assert property (p_inst) else $error("link or sequencer instrument wrong");
  a_del: assert property (p_del) else $error("main not deleted");
endmodule : mcr_router_checker
bind mcr_router mcr_router_checker mcr_router_checker_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .out_byte_o(out_byte_o), .out_valid_o(out_valid_o),
  .thru_mode_o(thru_mode_o), .cfg_o(cfg_o), .link_active_i(link_active_i), .seq_playing_i(seq_playing_i),
  .aux_delete_main_i(aux_delete_main_i), .inst_exists_o(inst_exists_o), .src_valid_i(src_valid_i),
  .src_i(src_i), .src_ready_o(src_ready_o), .eng_valid_o(eng_valid_o), .eng_o(eng_o),
  .loc_valid_o(loc_valid_o), .seq_start_o(seq_start_o));
`default_nettype wire

/* File: tb/mcr_midi_peer.sv */
`default_nettype none
module mcr_midi_peer (
  input  wire logic       mclk_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] out_byte_i,
  input  wire logic       out_valid_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_valid_o,
  output logic            out_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic       stall = 1'b0;
  // A slow listener is ready only every other cycle, so the sender must hold its byte
  assign out_ready_o = !(slow_i && stall);
  always @(negedge mclk_i) stall <= !stall;
  always @(posedge mclk_i) begin
    if (out_valid_i && out_ready_o) got.push_back(out_byte_i);
  end
  initial begin
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
  end
  // Idle line shows the inverse of the last byte, never a stale copy
  task automatic send(input logic [7:0] b);
    @(negedge mclk_i);
    rx_byte_o = b;
    rx_valid_o = 1'b1;
    @(negedge mclk_i);
    rx_byte_o = ~b;
    rx_valid_o = 1'b0;
  endtask : send
endmodule : mcr_midi_peer
`default_nettype wire

/* File: tb/mcr_router_bench.sv */
`default_nettype none
module mcr_router_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam mcr_pkg::mcr_cfg_s NV = '{rx_en: 3'h7, tx_en: 3'h1, local_en: 3'h0, panel_filter: 1'b0,
    omni: 1'b0, mono: 1'b1, clk_out_en: 1'b0, clk_in_en: 1'b1, force_out: 1'b0, base_ch: 4'h2};
  logic mclk_i = 1'b0, nrst_i = 1'b0, cfg_wr_i = 1'b0, slow = 1'b0;
  logic link_active_i = 1'b0, seq_playing_i = 1'b0, aux_create_main_i = 1'b0, aux_delete_main_i = 1'b0;
  logic src_valid_i = 1'b0, metro_tick_i = 1'b0, seq_start_i = 1'b0, seq_stop_i = 1'b0;
  logic [7:0] rx_byte, out_byte, inst_exists;
  logic rx_valid, out_valid, out_ready, thru, src_ready, eng_valid, loc_valid, start, tick;
  mcr_pkg::mcr_cfg_s c = NV, cfg_i = NV, cfg_o;
  mcr_pkg::mcr_src_s src_i = '0, loc;
  mcr_pkg::mcr_eng_s eng, last_eng;
  int failures = 0, check_count = 0, cyc = 0, eng_n = 0, loc_n = 0, start_n = 0, tick_n = 0, e;
  always #5 mclk_i = !mclk_i;
  mcr_router mcr_router_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
    .out_byte_o(out_byte), .out_valid_o(out_valid), .out_ready_i(out_ready), .thru_mode_o(thru),
    .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i), .nv_cfg_i(NV), .cfg_o(cfg_o), .link_active_i(link_active_i),
    .seq_playing_i(seq_playing_i), .aux_create_main_i(aux_create_main_i), .aux_delete_main_i(aux_delete_main_i),
    .inst_exists_o(inst_exists), .src_valid_i(src_valid_i), .src_i(src_i), .src_ready_o(src_ready),
    .eng_valid_o(eng_valid), .eng_o(eng), .loc_valid_o(loc_valid), .loc_o(loc), .metro_tick_i(metro_tick_i),
    .seq_start_i(seq_start_i), .seq_stop_i(seq_stop_i), .clk_tick_o(tick), .seq_start_o(start), .seq_stop_o());
  mcr_midi_peer mcr_midi_peer_i (.mclk_i(mclk_i), .slow_i(slow), .out_byte_i(out_byte), .out_valid_i(out_valid),
    .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .out_ready_o(out_ready));
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (eng_valid) eng_n <= eng_n + 1;
    if (eng_valid) last_eng <= eng;
    if (loc_valid) loc_n <= loc_n + 1;
    if (start) start_n <= start_n + 1;
    if (tick) tick_n <= tick_n + 1;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done;
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rxq(input logic [7:0] q[$]);
    foreach (q[i]) mcr_midi_peer_i.send(q[i]);
    repeat (3) @(negedge mclk_i);
  endtask : rxq
  task automatic set_cfg;
    @(negedge mclk_i);
    cfg_i = c;
    cfg_wr_i = 1'b1;
    @(negedge mclk_i);
    cfg_wr_i = 1'b0;
  endtask : set_cfg
  task automatic pulse(ref logic s);
    @(negedge mclk_i);
    s = 1'b1;
    @(negedge mclk_i);
    s = 1'b0;
    repeat (4) @(negedge mclk_i);
  endtask : pulse
  task automatic src_send(input logic [1:0] s, input logic [7:0] st);
    @(negedge mclk_i);
    src_i = '{src: s, msg: '{st, 8'h3c, 8'h40}};
    src_valid_i = 1'b1;
    do @(posedge mclk_i); while (src_ready !== 1'b1);
    @(negedge mclk_i);
    src_valid_i = 1'b0;
    repeat (8) @(negedge mclk_i);
  endtask : src_send
  task automatic out_is(input logic [7:0] b);
    check("out byte", mcr_midi_peer_i.got.size() > 0 ? mcr_midi_peer_i.got.pop_front() : 8'hxx, b);
  endtask : out_is
  initial begin
    repeat (3) @(negedge mclk_i);
    nrst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    c.local_en = 3'h7;
    check("stored cfg", cfg_o, c);
    check("instruments", inst_exists, 8'h01);
    check("thru", thru, 1'b0);
    rxq('{8'h93, 8'h3c, 8'h40});
    check("eng absent link", eng_n, 0);
    link_active_i = 1'b1;
    seq_playing_i = 1'b1;
    rxq('{8'h93, 8'h3c, 8'h40});
    check("instruments", inst_exists, 8'h07);
    check("eng link", {eng_n[3:0], last_eng.inst, last_eng.mono}, {4'h1, 3'h1, 1'b1});
    rxq('{8'h94, 8'h3c, 8'h40});
    check("eng seq", last_eng.inst, 3'h2);
    c.rx_en = 3'h5;
    set_cfg();
    rxq('{8'h93, 8'h3c, 8'h40});
    check("rx disabled", eng_n, 2);
    rxq('{8'hb2, 8'h7f, 8'h00, 8'hb3, 8'h7e, 8'h00});
    check("mode cc", {eng_n[3:0], cfg_o.mono}, {4'h2, 1'b0});
    c.mono = 1'b0;
    rxq('{8'hc2, 8'h05, 8'hb2, 8'h15, 8'h01});
    check("panel off", eng_n, 2);
    c.panel_filter = 1'b1;
    set_cfg();
    rxq('{8'hc2, 8'h05, 8'hb2, 8'h15, 8'h01});
    check("panel on", eng_n, 4);
    rxq('{8'h97, 8'h3c, 8'h40, 8'hf0, 8'h7d, 8'h02, 8'h05, 8'hf7, 8'h97, 8'h3c, 8'h40});
    check("extra create", {eng_n[3:0], inst_exists[5]}, {4'h4, 1'b1});
    rxq('{8'hc7, 8'h03, 8'h97, 8'h3c, 8'h40});
    check("extra note", {last_eng.inst, last_eng.msg.status}, {3'h5, 8'h97});
    c.omni = 1'b1;
    set_cfg();
    rxq('{8'h9b, 8'h3c, 8'h40, 8'hbe, 8'h7e, 8'h00});
    check("omni", {last_eng.inst, cfg_o.mono}, {3'h0, 1'b1});
    c.mono = 1'b1;
    e = eng_n;
    rxq('{8'hfa, 8'hf8, 8'hfb, 8'hf3, 8'h01});
    check("start rx", {tick_n[3:0], start_n[3:0], eng_n[3:0]}, {4'h1, 4'h1, e[3:0]});
    c.clk_in_en = 1'b0;
    set_cfg();
    rxq('{8'hfa});
    check("start off", start_n, 1);
    slow = 1'b1;
    mcr_midi_peer_i.got.delete();
    src_send(2'h1, 8'h90);
    src_send(2'h0, 8'hf2);
    src_send(2'h0, 8'h90);
    out_is(8'h92);
    out_is(8'h3c);
    out_is(8'h40);
    c.omni = 1'b0;
    c.tx_en = 3'h6;
    c.local_en = 3'h5;
    set_cfg();
    e = loc_n;
    src_send(2'h1, 8'h90);
    check("no local", loc_n, e);
    src_send(2'h2, 8'h90);
    check("local", loc_n, e + 1);
    out_is(8'h93);
    out_is(8'h3c);
    out_is(8'h40);
    out_is(8'h94);
    c.panel_filter = 1'b0;
    c.clk_out_en = 1'b1;
    set_cfg();
    mcr_midi_peer_i.got.delete();
    src_send(2'h1, 8'hc0);
    pulse(metro_tick_i);
    pulse(seq_start_i);
    out_is(8'hf8);
    out_is(8'hfa);
    c.clk_out_en = 1'b0;
    set_cfg();
    pulse(seq_stop_i);
    check("stop off", mcr_midi_peer_i.got.size(), 0);
    c.tx_en = 3'h0;
    set_cfg();
    rxq('{8'h92});
    check("thru on", thru, 1'b1);
    out_is(8'h92);
    rxq('{8'hf0, 8'h7d, 8'h01, 8'h00, 8'hf7});
    check("forced out", thru, 1'b0);
    c.tx_en = 3'h3;
    c.local_en = 3'h0;
    set_cfg();
    rxq('{8'hff});
    check("reset", {cfg_o.tx_en, cfg_o.local_en, cfg_o.omni, cfg_o.mono}, {3'h0, 3'h7, 2'h2});
    pulse(aux_delete_main_i);
    check("main deleted", inst_exists[0], 1'b0);
    pulse(aux_create_main_i);
    check("main back", inst_exists[0], 1'b1);
    test_done();
  end
endmodule : mcr_router_bench
`default_nettype wire
